/* File: rtl/ptimer_cfg.svh */
// register offsets, field positions and reset values of the periodic timer
// assumes inclusion by bare name from the design files
`ifndef PTIMER_CFG_SVH
`define PTIMER_CFG_SVH
`define OFF_CONTROL_0      12'h000
`define OFF_CONTROL_1      12'h004
`define OFF_COUNT_LOW      12'h008
`define OFF_COUNT_HIGH     12'h00C
`define OFF_COMPARE_A_LOW  12'h010
`define OFF_COMPARE_A_HIGH 12'h014
`define OFF_PERIOD_LOW     12'h018
`define OFF_PERIOD_HIGH    12'h01C
`define RST_CONTROL        8'h00
`define BIT_PAUSE          7
`define BIT_ON             3
`define BIT_INIT_LEVEL     3
`define BIT_POLARITY       2
`define BIT_TRIG_SRC       1
`define BIT_CLEAR_SEL      0
`define CONTROL_0_MASK     8'hF8
`define TIMER_WIDTH        10
`define COUNT_MAX          10'h3FF
`define HIGH_CLOCK_DIV     4
`endif

/* File: rtl/ptimer_pkg.sv */
// types shared by the periodic timer modules
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package ptimer_pkg;
  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_CAPTURE,
    MODE_PWM,
    MODE_COUNTER
  } op_mode_t;
  typedef enum logic [2:0] {
    CLK_SYS_DIV4,
    CLK_SYS,
    CLK_HIGH_DIV16,
    CLK_HIGH_DIV64,
    CLK_TBC_A,
    CLK_TBC_B,
    CLK_PIN_RISE,
    CLK_PIN_FALL
  } clk_sel_t;
endpackage
`default_nettype wire

/* File: rtl/ptimer_tick_if.sv */
// tick request and answer between the timer core and its clock selector
// assumes a single clock domain
`default_nettype none
interface ptimer_tick_if;
  logic [2:0] select;
  logic       tick;
  modport core (output select, input tick);
  modport gen  (input select, output tick);
endinterface
`default_nettype wire

/* File: rtl/ptimer_clock_select.sv */
// counter clock enable generator: prescalers and pin edge detection
// assumes timebase and pin inputs already synchronous to clk_sys
`default_nettype none
`include "ptimer_cfg.svh"
module ptimer_clock_select #(
  parameter int HIGH_DIV = `HIGH_CLOCK_DIV
) (
  input  wire logic   clk_sys,
  input  wire logic   rstn,
  input  wire logic   timebase_clock,
  input  wire logic   external_clock_pin,
  ptimer_tick_if.gen  tk
);
  logic [7:0] pre;
  logic       pin_d;
  logic       tb_d;
  logic       tick_r;
  wire        tick_div4  = pre[1:0] == 2'b11;
  wire        tick_div16 = pre[3:0] == 4'hF;
  wire        tick_div64 = pre[5:0] == 6'h3F;
  wire        pin_rise   = external_clock_pin & ~pin_d;
  wire        pin_fall   = ~external_clock_pin & pin_d;
  wire        tb_rise    = timebase_clock & ~tb_d;
  logic       next_tick;
  always_comb begin
    unique case (ptimer_pkg::clk_sel_t'(tk.select))
      ptimer_pkg::CLK_SYS_DIV4:   next_tick = tick_div4;
      ptimer_pkg::CLK_SYS:        next_tick = 1'b1;
      ptimer_pkg::CLK_HIGH_DIV16: next_tick = tick_div16;
      ptimer_pkg::CLK_HIGH_DIV64: next_tick = tick_div64;
      ptimer_pkg::CLK_TBC_A:      next_tick = tb_rise;
      ptimer_pkg::CLK_TBC_B:      next_tick = tb_rise;
      ptimer_pkg::CLK_PIN_RISE:   next_tick = pin_rise;
      ptimer_pkg::CLK_PIN_FALL:   next_tick = pin_fall;
    endcase
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pre    <= 8'h00;
      pin_d  <= 1'b0;
      tb_d   <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      pre    <= pre + 8'h01;
      pin_d  <= external_clock_pin;
      tb_d   <= timebase_clock;
      tick_r <= next_tick;
    end
  end
  assign tk.tick = tick_r;
endmodule
`default_nettype wire

/* File: rtl/ptimer_top.sv */
// periodic timer: axi4-lite register file, 10-bit counter, comparators,
// output and capture logic
// assumes inputs synchronous to clk_sys
//
// Behaviour
// - pause bit halts counter holding count; clearing resumes from held value
// - clock select: sys/4, sys, high/16, high/64, timebase x2, pin rise, pin fall
// - clearing on/off stops and keeps count; rising on/off zeroes counter
// - compare mode: rising on/off returns output to initial level
// - control 0 bits 2..0 read as zero
// - mode field: compare, capture, pwm/single pulse, timer/counter
// - timer/counter mode: output pin held low, initial level and polarity unused
// - compare mode a match: keep, low, high or toggle output
// - pwm mode: inactive, active, pwm waveform, single pulse
// - capture mode edge: rising, falling, both, disabled
// - requested match level equal to initial level gives no visible change
// - initial level bit: pre-match level, or pwm active level
// - polarity bit set inverts the output pins
// - capture trigger from capture pin or external clock pin
// - clear select: a match, or p match/overflow
// - overflow clear only when period value is all zero
// - clear select ignored in pwm, single pulse and capture modes
// - counter readable only, split low and high registers
// - compare a value read/write split low/high, unused bits zero
// - period value read/write split low/high, unused bits zero
// - comparators compare the count with compare a and period values
// - pwm duty at or above period gives full duty
`default_nettype none
`include "ptimer_cfg.svh"
module ptimer_top #(
  parameter int WIDTH = `TIMER_WIDTH
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timebase_clock,
  input  wire logic        external_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_output_pin,
  output logic             timer_output_pin_inverted,
  output logic             compare_a_event,
  output logic             period_event
);
  typedef logic [WIDTH-1:0] cnt_t;

  // control and data registers
  logic [7:0] control_0;
  logic [7:0] control_1;
  cnt_t       count;
  cnt_t       compare_a_value;
  cnt_t       period_compare_value;
  logic       out_level;
  logic       on_d;
  logic       cap_d;

  wire        counter_pause          = control_0[`BIT_PAUSE];
  wire [2:0]  counter_clock_select   = control_0[6:4];
  wire        timer_on_off           = control_0[`BIT_ON];
  wire [1:0]  operating_mode_select  = control_1[7:6];
  wire [1:0]  output_function_select = control_1[5:4];
  wire        output_initial_level   = control_1[`BIT_INIT_LEVEL];
  wire        output_polarity        = control_1[`BIT_POLARITY];
  wire        capture_trigger_source = control_1[`BIT_TRIG_SRC];
  wire        counter_clear_select   = control_1[`BIT_CLEAR_SEL];

  ptimer_pkg::op_mode_t mode;
  assign mode = ptimer_pkg::op_mode_t'(operating_mode_select);

  // clock selection
  ptimer_tick_if tk ();
  assign tk.select = counter_clock_select;
  ptimer_clock_select u_clk (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .timebase_clock     (timebase_clock),
    .external_clock_pin (external_clock_pin),
    .tk                 (tk)
  );

  // counter and comparators
  wire  on_rise   = timer_on_off & ~on_d;
  // the on-bit rising edge only zeroes the count, so a stale count cannot match there
  wire  running   = timer_on_off & ~on_rise & ~counter_pause & tk.tick;
  wire  match_a   = running & (count == compare_a_value);
  wire  match_p   = running & (count == period_compare_value);
  wire  overflow  = running & (count == cnt_t'(`COUNT_MAX));
  wire  is_pwm    = mode == ptimer_pkg::MODE_PWM;
  wire  single    = is_pwm & (output_function_select == 2'b11);
  wire  is_cmp    = (mode == ptimer_pkg::MODE_COMPARE) | (mode == ptimer_pkg::MODE_COUNTER);
  // a zero period lets the counter run to its top before wrapping
  wire  p_clear   = (period_compare_value == '0) ? overflow : match_p;
  wire  cmp_clear = counter_clear_select ? match_a : p_clear;
  // pwm and capture clear on the period match, or on overflow with a zero period; single pulse never clears
  wire  clear     = is_cmp ? cmp_clear : (single ? 1'b0 : p_clear);
  cnt_t next_count;
  assign next_count = on_rise ? '0 : (clear ? '0 : (running ? count + cnt_t'(1) : count));

  // capture source and edge
  wire  cap_src   = capture_trigger_source ? external_clock_pin : capture_input_pin;
  wire  cap_rise  = cap_src & ~cap_d;
  wire  cap_fall  = ~cap_src & cap_d;
  logic cap_hit;
  always_comb begin
    unique case (output_function_select)
      2'b00: cap_hit = cap_rise;
      2'b01: cap_hit = cap_fall;
      2'b10: cap_hit = cap_rise | cap_fall;
      2'b11: cap_hit = 1'b0;
    endcase
  end
  wire  capture = (mode == ptimer_pkg::MODE_CAPTURE) & timer_on_off & cap_hit;

  // compare mode output level
  logic next_out_level;
  always_comb begin
    next_out_level = out_level;
    if (on_rise) begin
      next_out_level = output_initial_level;
    end else if (match_a) begin
      unique case (output_function_select)
        2'b00: next_out_level = out_level;
        2'b01: next_out_level = 1'b0;
        2'b10: next_out_level = 1'b1;
        2'b11: next_out_level = ~out_level;
      endcase
    end
  end

  // pwm active phase: duty at or above period stays active all period
  wire  pwm_active = (count < compare_a_value) | (compare_a_value >= period_compare_value);
  logic pwm_level;
  always_comb begin
    unique case (output_function_select)
      2'b00: pwm_level = 1'b0;
      2'b01: pwm_level = 1'b1;
      2'b10: pwm_level = pwm_active;
      2'b11: pwm_level = timer_on_off;
    endcase
  end

  // the counter mode leaves the pin at a fixed low
  logic raw_out;
  always_comb begin
    unique case (mode)
      ptimer_pkg::MODE_COMPARE: raw_out = out_level;
      ptimer_pkg::MODE_PWM:     raw_out = pwm_level ~^ output_initial_level;
      ptimer_pkg::MODE_CAPTURE: raw_out = 1'b0;
      ptimer_pkg::MODE_COUNTER: raw_out = 1'b0;
    endcase
  end
  wire  pol_used  = output_polarity & (mode != ptimer_pkg::MODE_COUNTER);
  wire  next_pin  = raw_out ^ pol_used;

  // axi4-lite write path
  logic       aw_held;
  logic       w_held;
  logic [11:0] aw_addr;
  logic [7:0]  w_byte;
  wire        aw_take  = s_axi_awvalid & s_axi_awready;
  wire        w_take   = s_axi_wvalid & s_axi_wready;
  wire        have_aw  = aw_held | aw_take;
  wire        have_w   = w_held | w_take;
  wire [11:0] wr_addr  = aw_take ? s_axi_awaddr : aw_addr;
  wire [7:0]  wr_byte  = w_take ? s_axi_wdata[7:0] : w_byte;
  wire        wr_lane  = w_take ? s_axi_wstrb[0] : 1'b1;
  logic       wr_lane_q;
  wire        wr_do    = have_aw & have_w & ~s_axi_bvalid;
  wire        wr_en    = wr_do & (w_take ? wr_lane : wr_lane_q);
  wire        wr_hit   = (wr_addr[11:5] == 7'd0) & (wr_addr[1:0] == 2'b00);
  wire        sel_c0   = wr_en & (wr_addr == `OFF_CONTROL_0);
  wire        sel_c1   = wr_en & (wr_addr == `OFF_CONTROL_1);
  wire        sel_al   = wr_en & (wr_addr == `OFF_COMPARE_A_LOW);
  wire        sel_ah   = wr_en & (wr_addr == `OFF_COMPARE_A_HIGH);
  wire        sel_pl   = wr_en & (wr_addr == `OFF_PERIOD_LOW);
  wire        sel_ph   = wr_en & (wr_addr == `OFF_PERIOD_HIGH);

  // single pulse ends on an a match by clearing the on bit itself
  wire  sp_end  = single & match_a;
  wire  sp_trig = single & ~timer_on_off & (counter_clock_select[2:1] == 2'b11) & tk.tick;
  logic [7:0] next_c0;
  assign next_c0 = sel_c0 ? (wr_byte & `CONTROL_0_MASK) :
                   {control_0[7:4], (control_0[3] | sp_trig) & ~sp_end, 3'b000};
  cnt_t next_a;
  assign next_a = capture ? count :
                  sel_al ? {compare_a_value[WIDTH-1:8], wr_byte} :
                  sel_ah ? {wr_byte[WIDTH-9:0], compare_a_value[7:0]} : compare_a_value;
  cnt_t next_p;
  assign next_p = sel_pl ? {period_compare_value[WIDTH-1:8], wr_byte} :
                  sel_ph ? {wr_byte[WIDTH-9:0], period_compare_value[7:0]} :
                  period_compare_value;

  // axi4-lite read path
  logic [7:0] rd_byte;
  always_comb begin
    unique case (s_axi_araddr)
      `OFF_CONTROL_0:      rd_byte = control_0;
      `OFF_CONTROL_1:      rd_byte = control_1;
      `OFF_COUNT_LOW:      rd_byte = count[7:0];
      `OFF_COUNT_HIGH:     rd_byte = 8'(count[WIDTH-1:8]);
      `OFF_COMPARE_A_LOW:  rd_byte = compare_a_value[7:0];
      `OFF_COMPARE_A_HIGH: rd_byte = 8'(compare_a_value[WIDTH-1:8]);
      `OFF_PERIOD_LOW:     rd_byte = period_compare_value[7:0];
      `OFF_PERIOD_HIGH:    rd_byte = 8'(period_compare_value[WIDTH-1:8]);
      default:             rd_byte = 8'h00;
    endcase
  end
  wire rd_hit = (s_axi_araddr[11:5] == 7'd0) & (s_axi_araddr[1:0] == 2'b00);
  wire rd_do  = s_axi_arvalid & ~s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      control_0            <= `RST_CONTROL;
      control_1            <= `RST_CONTROL;
      count                <= '0;
      compare_a_value      <= '0;
      period_compare_value <= '0;
      out_level            <= 1'b0;
      on_d                 <= 1'b0;
      cap_d                <= 1'b0;
      timer_output_pin     <= 1'b0;
      timer_output_pin_inverted <= 1'b1;
      compare_a_event      <= 1'b0;
      period_event         <= 1'b0;
    end else begin
      control_0            <= next_c0;
      if (sel_c1) begin
        control_1 <= wr_byte;
      end
      count                <= next_count;
      compare_a_value      <= next_a;
      period_compare_value <= next_p;
      out_level            <= next_out_level;
      on_d                 <= timer_on_off;
      cap_d                <= cap_src;
      timer_output_pin     <= next_pin;
      timer_output_pin_inverted <= ~next_pin;
      // no p event when a match clears in compare modes
      compare_a_event      <= match_a | capture;
      period_event         <= match_p & ~(is_cmp & counter_clear_select);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_byte  <= 8'h00;
      wr_lane_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      aw_held <= have_aw & ~wr_do;
      w_held  <= have_w & ~wr_do;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_byte    <= s_axi_wdata[7:0];
        wr_lane_q <= s_axi_wstrb[0];
      end
      s_axi_awready <= ~(have_aw & ~wr_do) & ~(s_axi_bvalid & ~s_axi_bready) & ~wr_do;
      s_axi_wready  <= ~(have_w & ~wr_do) & ~(s_axi_bvalid & ~s_axi_bready) & ~wr_do;
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= rd_do;
      if (rd_do) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/ptimer_top_sva.sv */
// assertion checker bound to the periodic timer top
// assumes clk_sys with async active-low rstn, bus outputs registered
`default_nettype none
module ptimer_top_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_inverted
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wpend;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence
  property p_wresp; s_wtake |=> s_wpend; endproperty
  property p_brel; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
  property p_bcode; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
  property p_rans;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_rvalid && s_axi_arready;
  endproperty
  property p_rrel; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  // only the low byte of each word is implemented
  property p_rupper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
  property p_slverr; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000; endproperty
  property p_pair; timer_output_pin_inverted == !timer_output_pin; endproperty
  a_wresp: assert property (p_wresp) else $error("write answer missing");
  a_brel: assert property (p_brel) else $error("write answer not released");
  a_bcode: assert property (p_bcode) else $error("bad write response code");
  a_rans: assert property (p_rans) else $error("read answer missing");
  a_rrel: assert property (p_rrel) else $error("read answer not released");
  a_rupper: assert property (p_rupper) else $error("upper read bits set");
  a_slverr: assert property (p_slverr) else $error("error read with data");
  a_pair: assert property (p_pair) else $error("output pins not complementary");
endmodule
bind ptimer_top ptimer_top_chk i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_output_pin(timer_output_pin),
  .timer_output_pin_inverted(timer_output_pin_inverted));
`default_nettype wire

/* File: testbench/ptimer_top_tb.sv */
// register-level testbench of the periodic timer
// assumes valid/ready handshakes on every channel; responses always accepted
`default_nettype none
module ptimer_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rstn, awvalid, wvalid, arvalid, ext, cap;
  logic        awready, wready, bvalid, arready, rvalid, pin, pinb, a_ev, p_ev;
  logic [11:0] awaddr, araddr;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata, d, e;
  logic [1:0]  bresp, rresp, r;
  int          mismatches, checks;
  localparam logic [11:0] WA [7] = '{12'h000, 12'h000, 12'h014, 12'h01C, 12'h008, 12'h010, 12'h020};
  localparam logic [7:0]  WV [7] = '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h55, 8'h77, 8'h12};
  localparam logic [7:0]  WE [7] = '{8'hF8, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00};
  localparam logic        WS [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  localparam logic [1:0]  CI [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1};
  localparam logic        CO [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam logic        CP [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam logic        CX [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [1:0]  KI [6] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
  localparam logic        KS [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  localparam logic        KR [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  localparam logic        KX [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  ptimer_top i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .timebase_clock(1'b0), .external_clock_pin(ext), .capture_input_pin(cap),
    .timer_output_pin(pin), .timer_output_pin_inverted(pinb), .compare_a_event(a_ev),
    .period_event(p_ev));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // handshakes are sampled at the rising edge, before the design's updates land
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic s = 1'b1);
    logic aw, wd, got;
    aw = 1'b0;
    wd = 1'b0;
    got = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    wstrb <= {3'h0, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!got) begin
      @(posedge clk_sys);
      got = aw && wd && bvalid;
      r = bresp;
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic got;
    got = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    while (!got) begin
      @(posedge clk_sys);
      if (arready) begin
        arvalid <= 1'b0;
      end
      got = rvalid;
    end
    d = rdata;
    r = rresp;
  endtask
  // off first, so the mode never changes under a running counter
  task automatic cfg(input logic [7:0] c1);
    wr(12'h000, 8'h00);
    wr(12'h004, c1);
    wr(12'h000, 8'h18);
  endtask
  task automatic ev(input logic xa, input logic xp, input string n);
    logic sa, sp;
    sa = 1'b0;
    sp = 1'b0;
    repeat (24) begin
      @(negedge clk_sys);
      sa |= a_ev;
      sp |= p_ev;
    end
    check(n, sa, xa);
    check(n, sp, xp);
  endtask
  initial begin
    {rstn, awvalid, wvalid, arvalid, ext, cap} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    mismatches = 0;
    checks = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4));
      check("reset_value", d, 32'h0000_0000);
    end
    for (int i = 0; i < 7; i++) begin
      wr(WA[i], WV[i], WS[i]);
      rd(WA[i]);
      check("readback", d, {24'h00_0000, WE[i]});
    end
    check("unmapped_resp", r, 2'h2);
    wr(12'h002, 8'h01);
    check("unaligned_resp", r, 2'h2);
    wr(12'h014, 8'h00);
    wr(12'h01C, 8'h00);
    cfg(8'hC0);
    repeat (20) @(posedge clk_sys);
    wr(12'h000, 8'h98);
    rd(12'h008);
    e = d;
    rd(12'h008);
    check("paused", d, e);
    wr(12'h000, 8'h18);
    rd(12'h008);
    check("resumed", d > e, 1);
    wr(12'h000, 8'h10);
    rd(12'h008);
    e = d;
    rd(12'h008);
    check("stopped", d, e);
    wr(12'h000, 8'h18);
    rd(12'h008);
    check("restart", d < 8'h0A, 1);
    wr(12'h000, 8'h00);
    wr(12'h000, 8'h68);
    repeat (3) begin
      @(posedge clk_sys) ext <= 1'b1;
      @(posedge clk_sys) ext <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    rd(12'h008);
    check("pin_clock_count", d, 32'h0000_0003);
    wr(12'h010, 8'h05);
    wr(12'h018, 8'h02);
    cfg(8'h01);
    ev(1'b1, 1'b0, "clear_on_a");
    cfg(8'h00);
    ev(1'b0, 1'b1, "clear_on_p");
    for (int i = 0; i < 6; i++) begin
      cfg({2'h0, CI[i], CO[i], CP[i], 2'h1});
      // the initial level reaches the pin two edges after the on-bit edge
      repeat (2) @(negedge clk_sys);
      check("initial_level", pin, CO[i] ^ CP[i]);
      while (a_ev !== 1'b1) @(negedge clk_sys);
      repeat (2) @(negedge clk_sys);
      check("match_level", pin, CX[i]);
    end
    // duty 5 against period 2 must read as full duty
    for (int i = 0; i < 3; i++) begin
      cfg({2'h2, 2'(i), 4'h8});
      repeat (8) begin
        @(negedge clk_sys);
        check("pwm_level", pin, i != 0);
      end
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      cap <= ~KR[i];
      ext <= ~KR[i];
      // an earlier capture leaves compare a inside the count range; move it out
      wr(12'h010, 8'h05);
      cfg({2'h1, KI[i], 2'h0, KS[i], 1'b1});
      @(posedge clk_sys);
      if (KS[i]) ext <= KR[i];
      else cap <= KR[i];
      ev(KX[i], 1'b1, "capture");
    end
    tally_and_finish();
  end
  // the sequence needs some 600 cycles; this cuts a hang well after that
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
